// ### rcr_bank.sv
// Rail control register bank: three control registers and their rail outputs.
// Assumes a decoded byte write/read port from the serial interface, in mclk domain.
`timescale 1ns/1ns
module rcr_bank #(
  // Factory sleep-pin choice per rail: 0 pin one, 1 pin two
  parameter bit SW6_SLEEP_PIN_TWO = 1'b0,
  parameter bit LIN2_SLEEP_PIN_TWO = 1'b0,
  parameter bit LIN3_SLEEP_PIN_TWO = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input rcr_pkg::rcr_wr_t bus_wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic control_in_three_sleep_pin_one,
  input wire logic control_in_six_sleep_pin_two,
  input wire logic switcher_six_pin_enable,
  input wire logic linear_two_pin_enable,
  input wire logic linear_three_pin_enable,
  output rcr_pkg::rcr_rail_ctl_t switcher_six_ctl,
  output rcr_pkg::rcr_rail_ctl_t linear_two_ctl,
  output rcr_pkg::rcr_rail_ctl_t linear_three_ctl
);
  logic [7:0] sw6_val;
  logic [7:0] lin2_val;
  logic [7:0] lin3_val;
  logic [7:0] rd_data_d;
  logic [7:0] rd_data_q;
  logic sw6_pin;
  logic lin2_pin;
  logic lin3_pin;
  logic sw6_wr;
  logic lin2_wr;
  logic lin3_wr;
  logic [1:0] sw6_sel;
  logic [1:0] lin2_sel;
  logic [1:0] lin3_sel;

  // One decoded strobe per register; other offsets fall through
  assign sw6_wr = bus_wr.wr_en && (bus_wr.addr == rcr_pkg::RCR_OFS_SWITCHER_SIX);
  assign lin2_wr = bus_wr.wr_en && (bus_wr.addr == rcr_pkg::RCR_OFS_LINEAR_TWO);
  assign lin3_wr = bus_wr.wr_en && (bus_wr.addr == rcr_pkg::RCR_OFS_LINEAR_THREE);

  // Fixed routing, no register can reach it
  assign sw6_pin = SW6_SLEEP_PIN_TWO ? control_in_six_sleep_pin_two
                                     : control_in_three_sleep_pin_one;
  assign lin2_pin = LIN2_SLEEP_PIN_TWO ? control_in_six_sleep_pin_two
                                       : control_in_three_sleep_pin_one;
  assign lin3_pin = LIN3_SLEEP_PIN_TWO ? control_in_six_sleep_pin_two
                                       : control_in_three_sleep_pin_one;

  // Reserved fields below bit 6 are stored as written; software keeps them at the
  // documented patterns select codes limited to 00/11
  rcr_rail #(.RST_VAL(rcr_pkg::RCR_RST_SWITCHER), .HAS_MODE(1'b1)) u_sw6 (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(sw6_wr),
    .wdata(bus_wr.wdata),
    .sleep_pin(sw6_pin),
    .pin_enable(switcher_six_pin_enable),
    .value(sw6_val),
    .ctl(switcher_six_ctl)
  );
  rcr_rail #(.RST_VAL(rcr_pkg::RCR_RST_LINEAR), .HAS_MODE(1'b0)) u_lin2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(lin2_wr),
    .wdata(bus_wr.wdata),
    .sleep_pin(lin2_pin),
    .pin_enable(linear_two_pin_enable),
    .value(lin2_val),
    .ctl(linear_two_ctl)
  );
  rcr_rail #(.RST_VAL(rcr_pkg::RCR_RST_LINEAR), .HAS_MODE(1'b0)) u_lin3 (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(lin3_wr),
    .wdata(bus_wr.wdata),
    .sleep_pin(lin3_pin),
    .pin_enable(linear_three_pin_enable),
    .value(lin3_val),
    .ctl(linear_three_ctl)
  );

  always_comb begin
    rd_data_d = rd_data_q;
    if (ce) begin
      case (rd_addr)
        rcr_pkg::RCR_OFS_SWITCHER_SIX: rd_data_d = sw6_val;
        rcr_pkg::RCR_OFS_LINEAR_TWO: rd_data_d = lin2_val;
        rcr_pkg::RCR_OFS_LINEAR_THREE: rd_data_d = lin3_val;
        default: rd_data_d = rcr_pkg::RCR_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= rcr_pkg::RCR_RD_UNMAPPED;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

  // Select fields pulled out for the sleep checks
  assign sw6_sel = sw6_val[rcr_pkg::RCR_SLP_HI:rcr_pkg::RCR_SLP_LO];
  assign lin2_sel = lin2_val[rcr_pkg::RCR_SLP_HI:rcr_pkg::RCR_SLP_LO];
  assign lin3_sel = lin3_val[rcr_pkg::RCR_SLP_HI:rcr_pkg::RCR_SLP_LO];

  // Mode bit exists only on the switcher
  a_lin_no_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    !linear_two_ctl.pwm_force && !linear_three_ctl.pwm_force)
    else $error("linear rail shows a mode bit");
  a_sw6_mode_tracks: assert property (@(posedge mclk) disable iff (!rst_n)
    switcher_six_ctl.pwm_force == sw6_val[rcr_pkg::RCR_MODE_BIT])
    else $error("switcher mode not from bit 1");

  // On bit low wins over every pin; high hands the choice to the pins
  a_sw6_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !sw6_val[rcr_pkg::RCR_ON_BIT] |-> !switcher_six_ctl.enable)
    else $error("switcher on with bit clear");
  a_sw6_on_pins: assert property (@(posedge mclk) disable iff (!rst_n)
    sw6_val[rcr_pkg::RCR_ON_BIT] |-> switcher_six_ctl.enable == switcher_six_pin_enable)
    else $error("switcher enable not from pins");
  a_lin2_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !lin2_val[rcr_pkg::RCR_ON_BIT] |-> !linear_two_ctl.enable)
    else $error("linear two on with bit clear");
  a_lin2_on_pins: assert property (@(posedge mclk) disable iff (!rst_n)
    lin2_val[rcr_pkg::RCR_ON_BIT] |-> linear_two_ctl.enable == linear_two_pin_enable)
    else $error("linear two enable not from pins");
  a_lin3_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !lin3_val[rcr_pkg::RCR_ON_BIT] |-> !linear_three_ctl.enable)
    else $error("linear three on with bit clear");
  a_lin3_on_pins: assert property (@(posedge mclk) disable iff (!rst_n)
    lin3_val[rcr_pkg::RCR_ON_BIT] |-> linear_three_ctl.enable == linear_three_pin_enable)
    else $error("linear three enable not from pins");

  // Sleep code needs select 11 and the routed pin low; reserved codes act as 00
  a_sw6_sleep_on: assert property (@(posedge mclk) disable iff (!rst_n)
    sw6_sel == rcr_pkg::RCR_SLP_ON && !sw6_pin |-> switcher_six_ctl.use_sleep_code)
    else $error("switcher missed sleep code");
  a_sw6_sleep_off: assert property (@(posedge mclk) disable iff (!rst_n)
    sw6_sel == rcr_pkg::RCR_SLP_OFF |-> !switcher_six_ctl.use_sleep_code)
    else $error("switcher sleep code with select off");
  a_sw6_sleep_awake: assert property (@(posedge mclk) disable iff (!rst_n)
    sw6_pin |-> !switcher_six_ctl.use_sleep_code)
    else $error("switcher sleep code with pin high");
  a_lin2_sleep_on: assert property (@(posedge mclk) disable iff (!rst_n)
    lin2_sel == rcr_pkg::RCR_SLP_ON && !lin2_pin |-> linear_two_ctl.use_sleep_code)
    else $error("linear two missed sleep code");
  a_lin2_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
    lin2_sel == rcr_pkg::RCR_SLP_OFF |-> !linear_two_ctl.use_sleep_code)
    else $error("linear two sleep code with select off");
  a_lin2_sleep_awake: assert property (@(posedge mclk) disable iff (!rst_n)
    lin2_pin |-> !linear_two_ctl.use_sleep_code)
    else $error("linear two sleep code with pin high");
  a_lin3_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
    lin3_sel == rcr_pkg::RCR_SLP_ON && !lin3_pin |-> linear_three_ctl.use_sleep_code)
    else $error("linear three missed sleep code");
  a_lin3_sleep_off: assert property (@(posedge mclk) disable iff (!rst_n)
    lin3_sel == rcr_pkg::RCR_SLP_OFF |-> !linear_three_ctl.use_sleep_code)
    else $error("linear three sleep code with select off");
  a_lin3_sleep_awake: assert property (@(posedge mclk) disable iff (!rst_n)
    lin3_pin |-> !linear_three_ctl.use_sleep_code)
    else $error("linear three sleep code with pin high");

  // Writes land one edge later with the top two bits dropped
  a_sw6_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && bus_wr.wr_en && bus_wr.addr == rcr_pkg::RCR_OFS_SWITCHER_SIX
    |=> sw6_val == ($past(bus_wr.wdata) & rcr_pkg::RCR_WR_MASK))
    else $error("switcher write not stored masked");
  a_lin2_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && bus_wr.wr_en && bus_wr.addr == rcr_pkg::RCR_OFS_LINEAR_TWO
    |=> lin2_val == ($past(bus_wr.wdata) & rcr_pkg::RCR_WR_MASK))
    else $error("linear two write not stored masked");
  a_lin3_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && bus_wr.wr_en && bus_wr.addr == rcr_pkg::RCR_OFS_LINEAR_THREE
    |=> lin3_val == ($past(bus_wr.wdata) & rcr_pkg::RCR_WR_MASK))
    else $error("linear three write not stored masked");
  a_regs_top_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    ((sw6_val | lin2_val | lin3_val) & ~rcr_pkg::RCR_WR_MASK) == 8'h00)
    else $error("register top bits not zero");

  // Only an own, enabled write may move a rail's register
  a_sw6_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !(ce && bus_wr.wr_en && bus_wr.addr == rcr_pkg::RCR_OFS_SWITCHER_SIX)
    |=> $stable(sw6_val))
    else $error("switcher register changed without a write");
  a_lin2_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !(ce && bus_wr.wr_en && bus_wr.addr == rcr_pkg::RCR_OFS_LINEAR_TWO)
    |=> $stable(lin2_val))
    else $error("linear two register changed without a write");
  a_lin3_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !(ce && bus_wr.wr_en && bus_wr.addr == rcr_pkg::RCR_OFS_LINEAR_THREE)
    |=> $stable(lin3_val))
    else $error("linear three register changed without a write");

  // Read data is registered, so it shows the register as of the edge before
  a_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && rd_addr == rcr_pkg::RCR_OFS_LINEAR_TWO |=> rd_data == $past(lin2_val))
    else $error("linear two read data wrong");
  a_sw6_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && rd_addr == rcr_pkg::RCR_OFS_SWITCHER_SIX |=> rd_data == $past(sw6_val))
    else $error("switcher read data wrong");
  a_lin3_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && rd_addr == rcr_pkg::RCR_OFS_LINEAR_THREE |=> rd_data == $past(lin3_val))
    else $error("linear three read data wrong");
  a_read_top_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_data & ~rcr_pkg::RCR_WR_MASK) == 8'h00)
    else $error("read data top bits not zero");
endmodule : rcr_bank

// ### rcr_bank_bench.sv
// Self-checking bench for the rail control register bank.
// Assumes default factory sleep pin one for every rail.
`timescale 1ns/1ns
module rcr_bank_bench;
  logic mclk;
  logic rst_n;
  logic ce;
  rcr_pkg::rcr_wr_t bus_wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic pin_one;
  logic pin_two;
  logic [2:0] pin_en;
  rcr_pkg::rcr_rail_ctl_t ctl [3];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] ofs [3];

  rcr_bank rcr_bank_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .bus_wr(bus_wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .control_in_three_sleep_pin_one(pin_one),
    .control_in_six_sleep_pin_two(pin_two),
    .switcher_six_pin_enable(pin_en[0]),
    .linear_two_pin_enable(pin_en[1]),
    .linear_three_pin_enable(pin_en[2]),
    .switcher_six_ctl(ctl[0]),
    .linear_two_ctl(ctl[1]),
    .linear_three_ctl(ctl[2])
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic conclude();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // Whole run needs well under a few hundred cycles
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_wr <= '{1'b1, a, d};
    @(posedge mclk);
    bus_wr.wr_en <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    chk(rd_data, exp);
    @(posedge mclk);
  endtask : rd

  // Rail outputs are combinational, so look mid-cycle
  task automatic rail(input int i, input logic p1, input logic p2, input logic en,
                      input logic [2:0] exp);
    pin_one <= p1;
    pin_two <= p2;
    pin_en[i] <= en;
    @(negedge mclk);
    chk({5'h00, ctl[i]}, {5'h00, exp});
    @(posedge mclk);
  endtask : rail

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    bus_wr = '0;
    rd_addr = 8'h00;
    pin_one = 1'b1;
    pin_two = 1'b1;
    pin_en = 3'h7;
    ofs[0] = rcr_pkg::RCR_OFS_SWITCHER_SIX;
    ofs[1] = rcr_pkg::RCR_OFS_LINEAR_TWO;
    ofs[2] = rcr_pkg::RCR_OFS_LINEAR_THREE;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      rd(ofs[i], 8'h0c);
      rail(i, 1'b0, 1'b1, 1'b1, 3'b000);
      wr(ofs[i], 8'hfd);
      rd(ofs[i], 8'h3d);
      rail(i, 1'b1, 1'b1, 1'b1, 3'b100);
      rail(i, 1'b0, 1'b1, 1'b1, 3'b110);
      rail(i, 1'b1, 1'b0, 1'b1, 3'b100);
      rail(i, 1'b1, 1'b1, 1'b0, 3'b000);
      // Switcher gets forced pulse-width mode; linears have no mode bit
      wr(ofs[i], (i == 0) ? 8'h0f : 8'h0d);
      rail(i, 1'b0, 1'b1, 1'b1, (i == 0) ? 3'b101 : 3'b100);
      wr(ofs[i], 8'h3c);
      rail(i, 1'b0, 1'b1, 1'b1, 3'b010);
      ce <= 1'b0;
      wr(ofs[i], 8'h0d);
      ce <= 1'b1;
      rd(ofs[i], 8'h3c);
    end
    wr(8'h26, 8'hff);
    rd(8'h26, rcr_pkg::RCR_RD_UNMAPPED);
    rd(ofs[0], 8'h3c);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(ofs[0], rcr_pkg::RCR_RST_SWITCHER);
    conclude();
  end
endmodule : rcr_bank_bench

// ### rcr_pkg.sv
// Package for the rail control register bank: offsets, field layout, reset values.
// Assumes an 8-bit register port already decoded from the serial link.
package rcr_pkg;
  localparam logic [7:0] RCR_OFS_SWITCHER_SIX = 8'h27;
  localparam logic [7:0] RCR_OFS_LINEAR_TWO = 8'h28;
  localparam logic [7:0] RCR_OFS_LINEAR_THREE = 8'h29;
  localparam int RCR_SLP_HI = 5;
  localparam int RCR_SLP_LO = 4;
  localparam int RCR_MODE_BIT = 1;
  localparam int RCR_ON_BIT = 0;
  localparam logic [1:0] RCR_SLP_OFF = 2'h0;
  localparam logic [1:0] RCR_SLP_ON = 2'h3;
  // Writable masks; bits 7:6 are read-only zero
  localparam logic [7:0] RCR_WR_MASK = 8'h3f;
  // Reset images follow the factory table: reserved ones set, rest zero
  localparam logic [7:0] RCR_RST_SWITCHER = 8'h0c;
  localparam logic [7:0] RCR_RST_LINEAR = 8'h0c;
  localparam logic [7:0] RCR_RD_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    RCR_RAIL_SWITCHER_SIX = 2'b00,
    RCR_RAIL_LINEAR_TWO = 2'b01,
    RCR_RAIL_LINEAR_THREE = 2'b10
  } rcr_rail_t;

  typedef struct packed {
    logic enable;
    logic use_sleep_code;
    logic pwm_force;
  } rcr_rail_ctl_t;

  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcr_wr_t;
endpackage : rcr_pkg

// ### rcr_rail.sv
// One rail's control register with its decode of sleep select and on bit.
// Assumes the write strobe is already qualified by address match.
`timescale 1ns/1ns
module rcr_rail #(
  parameter logic [7:0] RST_VAL = rcr_pkg::RCR_RST_LINEAR,
  parameter bit HAS_MODE = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic sleep_pin,
  input wire logic pin_enable,
  output logic [7:0] value,
  output rcr_pkg::rcr_rail_ctl_t ctl
);
  logic [7:0] reg_q;
  logic [7:0] reg_d;

  always_comb begin
    reg_d = reg_q;
    if (ce && wr) begin
      reg_d = wdata & rcr_pkg::RCR_WR_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_q <= RST_VAL;
    end else begin
      reg_q <= reg_d;
    end
  end

  assign value = reg_q;

  always_comb begin
    // Reserved select codes act like 00: safest is the normal code
    ctl.use_sleep_code = (reg_q[rcr_pkg::RCR_SLP_HI:rcr_pkg::RCR_SLP_LO] == rcr_pkg::RCR_SLP_ON)
      && !sleep_pin;
    ctl.enable = reg_q[rcr_pkg::RCR_ON_BIT] && pin_enable;
    ctl.pwm_force = HAS_MODE ? reg_q[rcr_pkg::RCR_MODE_BIT] : 1'b0;
  end

  a_off_overrides: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_q[rcr_pkg::RCR_ON_BIT] |-> !ctl.enable)
    else $error("rail enabled while on bit clear");
  a_sleep_code_use: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl.use_sleep_code
    |-> (reg_q[rcr_pkg::RCR_SLP_HI:rcr_pkg::RCR_SLP_LO] == rcr_pkg::RCR_SLP_ON) && !sleep_pin)
    else $error("sleep code used without select and low pin");
  a_top_bits_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (value & ~rcr_pkg::RCR_WR_MASK) == 8'h00)
    else $error("reserved top bits not zero");
endmodule : rcr_rail
